// ### logic/pbb_pkg.sv
// Package of constants for the parallel bit-bang port
package pbb_pkg;
  localparam int        PBB_W          = 8;
  localparam int        PBB_FIFO_DEPTH = 16;
  localparam logic [7:0] PBB_MODE_OFF  = 8'h00;
  localparam logic [7:0] PBB_MODE_FREE = 8'h01;
  localparam logic [7:0] PBB_MODE_LOCK = 8'h04;
  localparam logic [7:0] PBB_DIR_RST   = 8'h00;
  localparam logic [7:0] PBB_OUT_RST   = 8'h00;
  localparam int        PBB_STRB_CYC   = 1;
endpackage : pbb_pkg

// ### logic/pbb_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pbb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } pbb_fifo_s;
  pbb_fifo_s st_reg;
  pbb_fifo_s st_next;
  logic      push;
  logic      pop;

  assign in_ready  = st_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : pbb_fifo

// ### logic/pbb_port.sv
// Byte-wide bit-bang port, free-running and lock-step variants
//
// Overview of operation
// - Free-running: each host byte goes to output pins without external clock.
// - Each of the eight pins is separately input or output.
// - Free-running byte rate is paced by the baud tick.
// - Free-running outputs hold last value; change needs new byte and a baud tick.
// - Free-running mode brings sample and update strobes out to pins.
// - Mode code 0x01 selects the free-running variant.
// - Lock-step updates outputs only when a host byte is delivered.
// - Lock-step pulses update strobe low after each byte is driven.
// - Lock-step samples pins only as part of a port write.
// - Lock-step stalls until the to-host buffer has room.
// - Pins sampled before driving, so samples lag outputs one byte.
// - Mode code 0x04 selects the lock-step variant.
// - Read pins, then deassert sample strobe while latching and forwarding.
// - Reassert sample strobe, drive outputs, wait 1 clock, then update strobe.
// - Sample strobe rising edge marks data captured for the host.
// - Direction mask comes with mode setup and holds until the next.
`timescale 1ns/100ps
module pbb_port (
  input  wire logic                       CLK,
  input  wire logic                       SRST,
  input  wire logic                       MODE_SET,
  input  wire logic [7:0]                 MODE_CODE,
  input  wire logic [pbb_pkg::PBB_W-1:0]  MODE_DIR,
  input  wire logic                       BAUD_TICK,
  input  wire logic [pbb_pkg::PBB_W-1:0]  RX_DATA,
  input  wire logic                       RX_VALID,
  output logic                            RX_READY,
  output logic      [pbb_pkg::PBB_W-1:0]  TX_DATA,
  output logic                            TX_VALID,
  input  wire logic                       TX_READY,
  input  wire logic [pbb_pkg::PBB_W-1:0]  PIN_IN,
  output logic      [pbb_pkg::PBB_W-1:0]  PIN_OUT,
  output logic      [pbb_pkg::PBB_W-1:0]  PIN_OE,
  output logic                     PIN_SAMPLE_STROBE_N,
  output logic                     PIN_UPDATE_STROBE_N,
  output logic                     MODE_FREE,
  output logic                     MODE_LOCK
);
  import pbb_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [2:0] {
    PBB_IDLE, PBB_SAMPLE, PBB_DRIVE, PBB_SETUP, PBB_STROBE
  } pbb_phase_e;

  typedef struct packed {
    logic [7:0]       mode;
    logic [PBB_W-1:0] dir;
    logic [PBB_W-1:0] out;
    logic [PBB_W-1:0] pend;
    logic [PBB_W-1:0] samp;
    logic             samp_n;
    logic             upd_n;
    pbb_phase_e       phase;
    logic [PBB_W-1:0] pin_s1;
    logic [PBB_W-1:0] pin_s2;
    logic             tick_s1;
    logic             tick_s2;
  } pbb_port_s;

  pbb_port_s st_reg;
  pbb_port_s st_next;

  logic             in_valid;
  logic             in_ready;
  logic [PBB_W-1:0] in_data;
  logic             take;
  logic             is_free;
  logic             is_lock;
  logic             tx_push;

  // ********************************************************************
  // Host byte buffer
  // ********************************************************************
  pbb_fifo #(.WIDTH(PBB_W), .DEPTH(PBB_FIFO_DEPTH)) u_rx_buf (
    .clk       (CLK),
    .srst      (SRST),
    .in_data   (RX_DATA),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .out_data  (in_data),
    .out_valid (in_valid),
    .out_ready (in_ready)
  );

  assign is_free = st_reg.mode == PBB_MODE_FREE;
  assign is_lock = st_reg.mode == PBB_MODE_LOCK;
  assign MODE_FREE = is_free;
  assign MODE_LOCK = is_lock;

  // Free: take on tick; lock: take only when idle and to-host has room
  assign take = in_valid && !MODE_SET &&
                ((is_free && st_reg.tick_s2) ||
                 (is_lock && st_reg.phase == PBB_IDLE && TX_READY));
  assign in_ready = take;
  assign tx_push  = is_lock && st_reg.phase == PBB_SAMPLE;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.pin_s1  = PIN_IN;
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.tick_s1 = BAUD_TICK;
    st_next.tick_s2 = st_reg.tick_s1;
    st_next.upd_n   = 1'b1;
    st_next.samp_n  = 1'b1;
    if (MODE_SET) begin
      st_next.mode  = MODE_CODE;
      st_next.dir   = MODE_DIR;
      st_next.phase = PBB_IDLE;
    end else if (is_free) begin
      if (take) begin
        st_next.out    = in_data;
        st_next.upd_n  = 1'b0;
        st_next.samp_n = 1'b0;
        st_next.samp   = st_reg.pin_s2;
      end
    end else if (is_lock) begin
      unique case (st_reg.phase)
        PBB_IDLE: begin
          if (take) begin
            st_next.pend   = in_data;
            st_next.samp   = st_reg.pin_s2;
            st_next.samp_n = 1'b0;
            st_next.phase  = PBB_SAMPLE;
          end
        end
        PBB_SAMPLE: begin
          st_next.out   = st_reg.pend;
          st_next.phase = PBB_SETUP;
        end
        PBB_SETUP: begin
          st_next.upd_n = 1'b0;
          st_next.phase = PBB_STROBE;
        end
        PBB_STROBE: begin
          st_next.phase = PBB_IDLE;
        end
        default: begin
          st_next.phase = PBB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg         <= '0;
      st_reg.mode    <= PBB_MODE_OFF;
      st_reg.dir     <= PBB_DIR_RST;
      st_reg.out     <= PBB_OUT_RST;
      st_reg.samp_n  <= 1'b1;
      st_reg.upd_n   <= 1'b1;
      st_reg.phase   <= PBB_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign PIN_OUT = st_reg.out & st_reg.dir;
  assign PIN_OE  = st_reg.dir;
  assign PIN_SAMPLE_STROBE_N = st_reg.samp_n;
  assign PIN_UPDATE_STROBE_N = st_reg.upd_n;
  assign TX_DATA  = st_reg.samp;
  assign TX_VALID = tx_push;

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence lock_take_s;
    is_lock && take;
  endsequence
  sequence lock_seq_s;
    !PIN_SAMPLE_STROBE_N ##1 PIN_SAMPLE_STROBE_N ##1 !PIN_UPDATE_STROBE_N;
  endsequence

  lock_strobes_a: assert property (@(posedge CLK) disable iff (SRST)
    lock_take_s |=> lock_seq_s)
    else $error("lock-step strobe order wrong");
  lock_room_a: assert property (@(posedge CLK) disable iff (SRST)
    lock_take_s |-> TX_READY)
    else $error("byte taken without to-host room");
  lock_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (is_lock && !MODE_SET && st_reg.phase != PBB_SAMPLE) |=>
      $stable(st_reg.out))
    else $error("lock-step output changed without a byte");
  free_tick_a: assert property (@(posedge CLK) disable iff (SRST)
    (is_free && take) |-> st_reg.tick_s2)
    else $error("free-running byte taken without tick");
  free_out_a: assert property (@(posedge CLK) disable iff (SRST)
    (is_free && take && !MODE_SET) |=> st_reg.out == $past(in_data))
    else $error("free-running byte not placed on pins");
  free_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (is_free && !take) |=> $stable(st_reg.out))
    else $error("output changed without a new byte");
  sample_tx_a: assert property (@(posedge CLK) disable iff (SRST)
    (is_lock && !PIN_SAMPLE_STROBE_N) |-> (TX_VALID &&
      TX_DATA == $past(st_reg.pin_s2)) ##1 PIN_SAMPLE_STROBE_N)
    else $error("sample not forwarded at strobe rise");
  dir_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    !$past(MODE_SET) |-> $stable(st_reg.dir))
    else $error("direction changed without mode setup");
  input_off_a: assert property (@(posedge CLK) disable iff (SRST)
    (PIN_OUT & ~PIN_OE) == '0)
    else $error("input pin bit driven");
endmodule : pbb_port

// ### sim/pbb_ext_logic.sv
// Far-side logic model: resolves the port pins and counts strobes
`timescale 1ns/100ps
module pbb_ext_logic #(
  parameter logic [7:0] EXT_VAL = 8'h3c
) (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic       sample_strobe_n,
  input  wire logic       update_strobe_n,
  output logic      [7:0] pin_in,
  output logic      [7:0] upd_cnt,
  output logic      [7:0] smp_cnt
);
  // Pins not driven by the port carry the outside logic's own level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : EXT_VAL[i];
    end
  end
  initial begin
    upd_cnt = 8'h00;
    smp_cnt = 8'h00;
  end
  always @(negedge update_strobe_n) upd_cnt <= upd_cnt + 8'h01;
  always @(posedge sample_strobe_n) smp_cnt <= smp_cnt + 8'h01;
endmodule : pbb_ext_logic

// ### sim/pbb_port_bench.sv
// Self-checking bench for the bit-bang port
`timescale 1ns/100ps
module pbb_port_bench;
  import pbb_pkg::*;
  localparam logic [7:0] EXT = 8'h3c;
  logic       CLK = 1'b0;
  logic       SRST = 1'b1;
  logic       MODE_SET = 1'b0;
  logic       BAUD_TICK = 1'b0;
  logic       RX_VALID, RX_READY, TX_VALID, TX_READY, SSN, USN, MFREE, MLOCK;
  logic [7:0] MODE_CODE, MODE_DIR, RX_DATA, TX_DATA, PIN_IN, PIN_OUT, PIN_OE;
  logic [7:0] upd, smp;
  logic [7:0] q[$];
  int         error_cnt = 0;
  int         n_checks = 0;
  int         cyc = 0;

  pbb_port DUT (.CLK(CLK), .SRST(SRST), .MODE_SET(MODE_SET),
    .MODE_CODE(MODE_CODE), .MODE_DIR(MODE_DIR), .BAUD_TICK(BAUD_TICK),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_SAMPLE_STROBE_N(SSN), .PIN_UPDATE_STROBE_N(USN),
    .MODE_FREE(MFREE), .MODE_LOCK(MLOCK));
  pbb_ext_logic #(.EXT_VAL(EXT)) ext (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .sample_strobe_n(SSN), .update_strobe_n(USN), .pin_in(PIN_IN),
    .upd_cnt(upd), .smp_cnt(smp));

  always #2.5 CLK = ~CLK;

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Samples headed for the host, and a cap on run length
  always @(posedge CLK) begin
    if (TX_VALID === 1'b1) q.push_back(TX_DATA);
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic step(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step

  function automatic logic [7:0] pins(logic [7:0] v, logic [7:0] d);
    return (v & d) | (EXT & ~d);
  endfunction : pins

  task automatic set_mode(logic [7:0] c, logic [7:0] d);
    MODE_CODE = c;
    MODE_DIR = d;
    MODE_SET = 1'b1;
    step(1);
    MODE_SET = 1'b0;
    step(1);
  endtask : set_mode

  // Leaves the byte offered; the caller withdraws it after a burst
  task automatic send(logic [7:0] b, output bit ok);
    RX_DATA = b;
    RX_VALID = 1'b1;
    ok = 0;
    for (int i = 0; i < 8 && !ok; i++) begin
      ok = (RX_READY === 1'b1);
      step(1);
    end
  endtask : send

  task automatic wait_q(int n);
    for (int i = 0; i < 300 && q.size() < n; i++) step(1);
    step(4);
  endtask : wait_q

  initial begin
    bit         ok;
    int         n;
    logic [7:0] p, u, s;
    MODE_CODE = 8'h00;
    MODE_DIR = 8'h00;
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
    TX_READY = 1'b1;
    step(2);
    SRST = 1'b0;
    check("reset oe", PIN_OE, PBB_DIR_RST);
    check("reset flags", {3'h0, SSN, USN, RX_READY, MFREE, MLOCK}, 8'h1c);
    // ***************************************************
    // Lock-step: sample lag, strobes, direction mask
    // ***************************************************
    set_mode(PBB_MODE_LOCK, 8'hf0);
    check("lock flags", {6'h0, MFREE, MLOCK}, 8'h01);
    u = upd;
    s = smp;
    send(8'h55, ok);
    send(8'haa, ok);
    send(8'haa, ok);
    RX_VALID = 1'b0;
    wait_q(3);
    check("sample 0", q[0], pins(8'h00, 8'hf0));
    check("sample 1", q[1], pins(8'h55, 8'hf0));
    check("sample 2", q[2], pins(8'haa, 8'hf0));
    check("lock out", PIN_OUT, 8'ha0);
    check("lock oe", PIN_OE, 8'hf0);
    check("update pulses", upd - u, 8'h03);
    check("sample rises", smp - s, 8'h03);
    // Stall on a full to-host side, fill the byte buffer, then drain
    TX_READY = 1'b0;
    q.delete();
    n = 0;
    ok = 1;
    while (ok && n < 20) begin
      send(8'(n * 16), ok);
      n += int'(ok);
    end
    RX_VALID = 1'b0;
    check("fill count", 8'(n), 8'(PBB_FIFO_DEPTH));
    check("stall out", PIN_OUT, 8'ha0);
    check("stall tx", 8'(q.size()), 8'h00);
    TX_READY = 1'b1;
    wait_q(16);
    check("drain first", q[0], pins(8'haa, 8'hf0));
    check("drain last", q[15], pins(8'he0, 8'hf0));
    check("drain out", PIN_OUT, 8'hf0);
    check("drain ready", {7'h0, RX_READY}, 8'h01);
    // ***************************************************
    // Free-running: paced by the tick, holds without one
    // ***************************************************
    set_mode(PBB_MODE_FREE, 8'hff);
    check("free flags", {6'h0, MFREE, MLOCK}, 8'h02);
    check("free oe", PIN_OE, 8'hff);
    p = PIN_OUT;
    u = upd;
    s = smp;
    q.delete();
    send(8'h96, ok);
    send(8'h69, ok);
    RX_VALID = 1'b0;
    step(8);
    check("no tick hold", PIN_OUT, p);
    for (int k = 0; k < 2; k++) begin
      BAUD_TICK = 1'b1;
      step(1);
      BAUD_TICK = 1'b0;
      step(6);
      check("free out", PIN_OUT, k == 0 ? 8'h96 : 8'h69);
    end
    check("free pulses", upd - u, 8'h02);
    check("free samples", smp - s, 8'h02);
    check("free no tx", 8'(q.size()), 8'h00);
    set_mode(PBB_MODE_OFF, 8'h00);
    check("off flags", {6'h0, MFREE, MLOCK}, 8'h00);
    check("off oe", PIN_OE, 8'h00);
    give_verdict();
  end
endmodule : pbb_port_bench
